// >>> src/sor_pkg.sv
// Purpose: Constants and types for the system option and part id bank
// Assumes: 32-bit APB, 8-bit registers in the low byte lanes
// Notes:   Offsets and reset values are named here only
//
// Behaviour
// [RQ1] First option register: first write only, readable
// [RQ2] Bits 7:6 select watchdog timeout
// [RQ3] Bit 5 permits stop, else illegal-opcode reset
// [RQ4] Bit 2 moves two-wire pins A2/A3 to B6/B7
// [RQ5] Second register bit 7 selects watchdog clock
// [RQ6] Window mode: early status write resets
// [RQ7] Window mode only with bus clock selected
// [RQ8] Write-once bits of second register lock
// [RQ9] Bit 4 links comparator to timer A ch0
// [RQ10] Bit 3 moves timer B ch1 B4 to A7
// [RQ11] Bit 2 moves timer B ch0 A1 to A6
// [RQ12] Bit 1 moves timer A ch1 B5 to C1
// [RQ13] Bit 0 moves timer A ch0 A0 to C0
// [RQ14] Fixed read-only 12-bit part number
// [RQ15] High id bit 7 fixed series marker
// [RQ16] High id bits 6:4 reserved, read zero
// [RQ17] Routing follows register bit from accepted write
package sor_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [11:0] SOR_OFS_OPT1   = 12'h000;
    localparam logic [11:0] SOR_OFS_OPT2   = 12'h004;
    localparam logic [11:0] SOR_OFS_IDH    = 12'h008;
    localparam logic [11:0] SOR_OFS_IDL    = 12'h00C;
    localparam logic [11:0] SOR_OFS_STAT   = 12'h010;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int SOR_B_TMO_HI  = 7;
    localparam int SOR_B_TMO_LO  = 6;
    localparam int SOR_B_STOP    = 5;
    localparam int SOR_B_TWPS    = 2;
    localparam int SOR_B_WCLK    = 7;
    localparam int SOR_B_WWIN    = 6;
    localparam int SOR_B_CLINK   = 4;
    localparam int SOR_B_TB1     = 3;
    localparam int SOR_B_TB0     = 2;
    localparam int SOR_B_TA1     = 1;
    localparam int SOR_B_TA0     = 0;

    // ************************************************************
    // Reset values, masks, identity
    // ************************************************************
    localparam logic [7:0]  SOR_OPT1_RST   = 8'h00;
    localparam logic [7:0]  SOR_OPT2_RST   = 8'h00;
    localparam logic [7:0]  SOR_OPT1_WMASK = 8'hE4;
    localparam logic [7:0]  SOR_OPT2_FMASK = 8'h1F;
    // Arbitrary value
    localparam logic [11:0] SOR_PART_ID    = 12'h5C3;
    localparam logic        SOR_SERIES_BIT = 1'b1;
    localparam int          SOR_NCH        = 6;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        SOR_IDLE = 2'b01,
        SOR_ACK  = 2'b10
    } sor_apb_st_t;

    typedef struct packed {
        logic o;
        logic oe;
    } sor_drv_t;

    typedef struct packed {
        sor_apb_st_t  st;
        logic         ready;
        logic         slverr;
        logic [31:0]  rdata;
        logic [7:0]   opt1;
        logic         opt1_lock;
        logic [7:0]   opt2;
        logic         opt2_lock;
        logic         analog_comparator_s1;
        logic         analog_comparator_s2;
        logic         cap;
        logic         win_eff;
        logic         stop_enter;
        logic         ill_stop;
        logic         win_rst;
    } sor_state_t;

    typedef struct packed {
        logic [1:0]   s1;
        logic [1:0]   s2;
        sor_drv_t     drv_a;
        sor_drv_t     drv_b;
        logic         pin_in;
    } sor_route_t;

endpackage

// >>> src/sor_pin_route.sv
// Purpose: One peripheral signal steered between two pins
// Assumes: Pin levels are asynchronous to core_clk
// Notes:   Drive and input are registered
`timescale 1ns/100ps
module sor_pin_route (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             resetn,
    // Select
    input  wire logic             sel,
    // Peripheral side
    input  wire sor_pkg::sor_drv_t periph_drv,
    output logic                  periph_in,
    // Pin side
    input  wire logic             pin_a_in,
    input  wire logic             pin_b_in,
    output sor_pkg::sor_drv_t     pin_a_drv,
    output sor_pkg::sor_drv_t     pin_b_drv
);

    sor_pkg::sor_route_t r_reg;
    sor_pkg::sor_route_t r_next;

    // ************************************************************
    // Steering
    // ************************************************************
    always_comb begin
        r_next       = r_reg;
        r_next.s1    = {pin_b_in, pin_a_in};
        r_next.s2    = r_reg.s1;
        r_next.drv_a = sel ? '0 : periph_drv;
        r_next.drv_b = sel ? periph_drv : '0;
        r_next.pin_in = sel ? r_reg.s2[1] : r_reg.s2[0];
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign periph_in = r_reg.pin_in;
    assign pin_a_drv = r_reg.drv_a;
    assign pin_b_drv = r_reg.drv_b;

endmodule // sor_pin_route

// >>> src/sor_opt_regs.sv
// Purpose: System option and part id register bank on APB
// Assumes: Stop and status-write strobes come from core_clk logic
// Notes:   Channel order 0 SDA, 1 SCL, 2 B1, 3 B0, 4 A1, 5 A0
`timescale 1ns/100ps
module sor_opt_regs (
    // Clock and reset
    input  wire logic                     CORE_CLK,
    input  wire logic                     RESETN,
    // APB slave
    input  wire logic                     PSEL,
    input  wire logic                     PENABLE,
    input  wire logic                     PWRITE,
    input  wire logic [11:0]              PADDR,
    input  wire logic [31:0]              PWDATA,
    input  wire logic [3:0]               PSTRB,
    output logic                          PREADY,
    output logic                          PSLVERR,
    output logic [31:0]                   PRDATA,
    // Watchdog controls
    output logic [1:0]                    WDOG_TIMEOUT_SEL,
    output logic                          WDOG_CLOCK_SEL,
    output logic                          WDOG_WINDOW_EN,
    input  wire logic                     RST_STATUS_WR,
    input  wire logic                     WDOG_LATE_QUARTER,
    output logic                          WDOG_WINDOW_RESET,
    // Stop control
    input  wire logic                     STOP_EXEC,
    output logic                          STOP_PERMIT,
    output logic                          STOP_ENTER,
    output logic                          ILLEGAL_STOP_RESET,
    // Comparator link
    input  wire logic                     ANALOG_COMPARATOR_OUT,
    output logic                          COMP_CAPTURE_LINK,
    output logic                          TIMER_A_CH0_CAPTURE,
    // Routed peripheral signals
    input  wire sor_pkg::sor_drv_t [5:0]  PERIPH_DRV,
    output sor_pkg::sor_drv_t [5:0]       PIN_A_DRV,
    output sor_pkg::sor_drv_t [5:0]       PIN_B_DRV,
    input  wire logic [5:0]               PIN_A_IN,
    input  wire logic [5:0]               PIN_B_IN,
    output logic [5:0]                    PERIPH_IN
);

    // ************************************************************
    // State
    // ************************************************************
    sor_pkg::sor_state_t st_reg;
    sor_pkg::sor_state_t st_next;
    logic [5:0]          route_sel;
    logic                hit;
    logic [7:0]          rd_byte;

    // ************************************************************
    // Address decode and read mux
    // ************************************************************
    always_comb begin
        hit     = 1'b1;
        rd_byte = 8'h00;
        unique case (PADDR)
            sor_pkg::SOR_OFS_OPT1: begin
                rd_byte = st_reg.opt1; // [RQ1]
            end
            sor_pkg::SOR_OFS_OPT2: begin
                rd_byte = st_reg.opt2;
            end
            sor_pkg::SOR_OFS_IDH: begin
                rd_byte = {sor_pkg::SOR_SERIES_BIT, // [RQ15]
                           3'h0, // [RQ16]
                           sor_pkg::SOR_PART_ID[11:8]}; // [RQ14]
            end
            sor_pkg::SOR_OFS_IDL: begin
                rd_byte = sor_pkg::SOR_PART_ID[7:0]; // [RQ14]
            end
            sor_pkg::SOR_OFS_STAT: begin
                rd_byte = {5'h00, st_reg.win_eff,
                           st_reg.opt2_lock, st_reg.opt1_lock};
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        st_next = st_reg;

        // APB handshake, one access-phase cycle
        unique case (st_reg.st)
            sor_pkg::SOR_IDLE: begin
                st_next.ready  = 1'b0;
                st_next.slverr = 1'b0;
                st_next.rdata  = 32'h0000_0000;
                if (PSEL && !PENABLE) begin
                    st_next.st     = sor_pkg::SOR_ACK;
                    st_next.ready  = 1'b1;
                    st_next.slverr = !hit;
                    st_next.rdata  = PWRITE ? 32'h0000_0000
                                            : {24'h00_0000, rd_byte};
                end
            end
            sor_pkg::SOR_ACK: begin
                st_next.st     = sor_pkg::SOR_IDLE;
                st_next.ready  = 1'b0;
                st_next.slverr = 1'b0;
                st_next.rdata  = 32'h0000_0000;
                if (PSEL && PENABLE && PWRITE && PSTRB[0]) begin
                    // Option register one, whole register write-once
                    if (PADDR == sor_pkg::SOR_OFS_OPT1 &&
                        !st_reg.opt1_lock) begin
                        st_next.opt1 = PWDATA[7:0] &
                                       sor_pkg::SOR_OPT1_WMASK; // [RQ1]
                        st_next.opt1_lock = 1'b1; // [RQ1]
                    end
                    // Option register two
                    if (PADDR == sor_pkg::SOR_OFS_OPT2) begin
                        st_next.opt2 = (st_reg.opt2 &
                                        ~sor_pkg::SOR_OPT2_FMASK) |
                                       (PWDATA[7:0] &
                                        sor_pkg::SOR_OPT2_FMASK);
                        if (!st_reg.opt2_lock) begin
                            st_next.opt2[sor_pkg::SOR_B_WCLK] =
                                PWDATA[sor_pkg::SOR_B_WCLK]; // [RQ5]
                            st_next.opt2[sor_pkg::SOR_B_WWIN] =
                                PWDATA[sor_pkg::SOR_B_WWIN]; // [RQ8]
                            st_next.opt2_lock = 1'b1; // [RQ8]
                        end
                    end
                end
            end
            default: begin
                st_next.st     = sor_pkg::SOR_IDLE;
                st_next.ready  = 1'b0;
                st_next.slverr = 1'b0;
                st_next.rdata  = 32'h0000_0000;
            end
        endcase

        // Window mode only counts with the bus clock source
        st_next.win_eff = st_next.opt2[sor_pkg::SOR_B_WCLK] &
                          st_next.opt2[sor_pkg::SOR_B_WWIN]; // [RQ7]

        // Comparator synchroniser and capture link
        st_next.analog_comparator_s1 = ANALOG_COMPARATOR_OUT;
        st_next.analog_comparator_s2 = st_reg.analog_comparator_s1;
        st_next.cap     = st_reg.opt2[sor_pkg::SOR_B_CLINK] ?
                          st_reg.analog_comparator_s2 : PERIPH_IN[5]; // [RQ9]

        // Stop instruction outcome
        st_next.stop_enter = STOP_EXEC &
                             st_reg.opt1[sor_pkg::SOR_B_STOP]; // [RQ3]
        st_next.ill_stop   = STOP_EXEC &
                             !st_reg.opt1[sor_pkg::SOR_B_STOP]; // [RQ3]

        // Early status write in window mode
        st_next.win_rst = RST_STATUS_WR & st_reg.win_eff &
                          !WDOG_LATE_QUARTER; // [RQ6]
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            st_reg           <= '0;
            st_reg.st        <= sor_pkg::SOR_IDLE;
            st_reg.opt1      <= sor_pkg::SOR_OPT1_RST;
            st_reg.opt2      <= sor_pkg::SOR_OPT2_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // ************************************************************
    // Pin routing
    // ************************************************************
    // Selects taken from the next state so pins move with the write
    assign route_sel[0] = st_next.opt1[sor_pkg::SOR_B_TWPS]; // [RQ4]
    assign route_sel[1] = st_next.opt1[sor_pkg::SOR_B_TWPS]; // [RQ4]
    assign route_sel[2] = st_next.opt2[sor_pkg::SOR_B_TB1]; // [RQ10]
    assign route_sel[3] = st_next.opt2[sor_pkg::SOR_B_TB0]; // [RQ11]
    assign route_sel[4] = st_next.opt2[sor_pkg::SOR_B_TA1]; // [RQ12]
    assign route_sel[5] = st_next.opt2[sor_pkg::SOR_B_TA0]; // [RQ13]

    // Each channel registered, drives updated at the write edge
    generate
        for (genvar ch = 0; ch < sor_pkg::SOR_NCH; ch++) begin : g_route
            sor_pin_route u_route (
                .core_clk   (CORE_CLK),
                .resetn     (RESETN),
                .sel        (route_sel[ch]), // [RQ17]
                .periph_drv (PERIPH_DRV[ch]),
                .periph_in  (PERIPH_IN[ch]),
                .pin_a_in   (PIN_A_IN[ch]),
                .pin_b_in   (PIN_B_IN[ch]),
                .pin_a_drv  (PIN_A_DRV[ch]),
                .pin_b_drv  (PIN_B_DRV[ch])
            );
        end
    endgenerate

    // ************************************************************
    // Outputs
    // ************************************************************
    assign PREADY   = st_reg.ready;
    assign PSLVERR  = st_reg.slverr;
    assign PRDATA   = st_reg.rdata;

    assign WDOG_TIMEOUT_SEL =
        st_reg.opt1[sor_pkg::SOR_B_TMO_HI:sor_pkg::SOR_B_TMO_LO]; // [RQ2]
    assign WDOG_CLOCK_SEL    = st_reg.opt2[sor_pkg::SOR_B_WCLK]; // [RQ5]
    assign WDOG_WINDOW_EN    = st_reg.win_eff; // [RQ7]
    assign WDOG_WINDOW_RESET = st_reg.win_rst; // [RQ6]

    assign STOP_PERMIT        = st_reg.opt1[sor_pkg::SOR_B_STOP]; // [RQ3]
    assign STOP_ENTER         = st_reg.stop_enter;
    assign ILLEGAL_STOP_RESET = st_reg.ill_stop;

    assign COMP_CAPTURE_LINK   = st_reg.opt2[sor_pkg::SOR_B_CLINK]; // [RQ9]
    assign TIMER_A_CH0_CAPTURE = st_reg.cap;

endmodule // sor_opt_regs

// >>> tb/sor_opt_regs_properties.sv
// Purpose: Port-level checks of the option and id bank
// Assumes: Single clock domain, async active-low reset
// Notes:   Attached to the top module by bind
`timescale 1ns/100ps
module sor_opt_regs_props (
    // Clock and reset
    input wire logic        CORE_CLK,
    input wire logic        RESETN,
    // APB
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic        PREADY,
    input wire logic [31:0] PRDATA,
    // Stop and watchdog
    input wire logic        STOP_EXEC,
    input wire logic        STOP_PERMIT,
    input wire logic        STOP_ENTER,
    input wire logic        ILLEGAL_STOP_RESET,
    input wire logic        WDOG_CLOCK_SEL,
    input wire logic        WDOG_WINDOW_EN,
    input wire logic        RST_STATUS_WR,
    input wire logic        WDOG_LATE_QUARTER,
    input wire logic        WDOG_WINDOW_RESET
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);
    // ************************************************************
    // Properties
    // ************************************************************
    property p_stop_enter;
        STOP_EXEC && STOP_PERMIT |=> STOP_ENTER && !ILLEGAL_STOP_RESET;
    endproperty
    a_stop_enter: assert property (p_stop_enter) else $error("stop not entered");
    property p_ill_stop;
        STOP_EXEC && !STOP_PERMIT |=> ILLEGAL_STOP_RESET && !STOP_ENTER;
    endproperty
    a_ill_stop: assert property (p_ill_stop) else $error("no illegal stop reset");
    property p_no_stop;
        !STOP_EXEC |=> !STOP_ENTER && !ILLEGAL_STOP_RESET;
    endproperty
    a_no_stop: assert property (p_no_stop) else $error("stray stop pulse");
    property p_permit_hold;
        STOP_PERMIT |=> STOP_PERMIT;
    endproperty
    a_permit_hold: assert property (p_permit_hold) else $error("stop permit changed");
    property p_clk_hold;
        WDOG_CLOCK_SEL |=> WDOG_CLOCK_SEL;
    endproperty
    a_clk_hold: assert property (p_clk_hold) else $error("clock select changed");
    property p_win_en;
        WDOG_WINDOW_EN |-> WDOG_CLOCK_SEL;
    endproperty
    a_win_en: assert property (p_win_en) else $error("window without bus clock");
    property p_win_rst;
        RST_STATUS_WR && WDOG_WINDOW_EN && !WDOG_LATE_QUARTER |=> WDOG_WINDOW_RESET;
    endproperty
    a_win_rst: assert property (p_win_rst) else $error("early write not reset");
    property p_win_ok;
        !(RST_STATUS_WR && WDOG_WINDOW_EN && !WDOG_LATE_QUARTER) |=> !WDOG_WINDOW_RESET;
    endproperty
    a_win_ok: assert property (p_win_ok) else $error("stray window reset");
    property p_idh;
        PSEL && PENABLE && PREADY && !PWRITE && PADDR == 12'h008 |->
            PRDATA == {24'h00_0000, sor_pkg::SOR_SERIES_BIT, 3'b000, sor_pkg::SOR_PART_ID[11:8]};
    endproperty
    a_idh: assert property (p_idh) else $error("bad high id read");
endmodule // sor_opt_regs_props
bind sor_opt_regs sor_opt_regs_props u_props (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PREADY(PREADY), .PRDATA(PRDATA),
    .STOP_EXEC(STOP_EXEC), .STOP_PERMIT(STOP_PERMIT), .STOP_ENTER(STOP_ENTER),
    .ILLEGAL_STOP_RESET(ILLEGAL_STOP_RESET), .WDOG_CLOCK_SEL(WDOG_CLOCK_SEL),
    .WDOG_WINDOW_EN(WDOG_WINDOW_EN), .RST_STATUS_WR(RST_STATUS_WR),
    .WDOG_LATE_QUARTER(WDOG_LATE_QUARTER), .WDOG_WINDOW_RESET(WDOG_WINDOW_RESET));

// >>> tb/system_option_and_id_regs_test.sv
// Purpose: Self-checking bench of the option and id bank
// Assumes: APB master in the bench, model of the registers beside it
// Notes:   Four resets cover every timeout code and clock/window pair
`timescale 1ns/100ps
module system_option_and_id_regs_test;
    logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, rnd = 32'h0000_e4b1;
    logic [3:0]  pstrb = 0;
    logic [1:0]  tmo;
    logic wclk, wwin, rst_wr = 0, late = 0, wrst, stop_exec = 0, permit, s_enter, s_ill;
    logic analog_comparator = 0, link, cap, er;
    sor_pkg::sor_drv_t [5:0] periph_drv = 0, pin_a_drv, pin_b_drv;
    logic [5:0]  pin_a_in = 0, pin_b_in = 0, periph_in, sel;
    logic [11:0] ea, eb;
    logic [7:0]  m1, m2, v1, v2;
    logic        l1, l2;
    int          err_count = 0, n_compared = 0;

    sor_opt_regs DUT (.CORE_CLK(clk), .RESETN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PREADY(pready), .PSLVERR(pslverr),
        .PRDATA(prdata), .WDOG_TIMEOUT_SEL(tmo), .WDOG_CLOCK_SEL(wclk), .WDOG_WINDOW_EN(wwin),
        .RST_STATUS_WR(rst_wr), .WDOG_LATE_QUARTER(late), .WDOG_WINDOW_RESET(wrst),
        .STOP_EXEC(stop_exec), .STOP_PERMIT(permit), .STOP_ENTER(s_enter), .ILLEGAL_STOP_RESET(s_ill),
        .ANALOG_COMPARATOR_OUT(analog_comparator), .COMP_CAPTURE_LINK(link), .TIMER_A_CH0_CAPTURE(cap), .PERIPH_DRV(periph_drv),
        .PIN_A_DRV(pin_a_drv), .PIN_B_DRV(pin_b_drv), .PIN_A_IN(pin_a_in), .PIN_B_IN(pin_b_in),
        .PERIPH_IN(periph_in));

    initial begin
        forever #50 clk = ~clk;
    end

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task conclude;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
        @(posedge clk);
        penable <= 1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata; er = pslverr;
        psel <= 0; penable <= 0;
        @(posedge clk);
    endtask

    task wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
        apb(1, a, {24'h00_0000, d}, s);
        if (s[0] && a == 12'h000 && !l1) begin
            m1 = d & 8'hE4; l1 = 1;
        end
        if (s[0] && a == 12'h004) begin
            m2 = l2 ? ((m2 & 8'hC0) | (d & 8'h1F)) : (d & 8'hDF); l2 = 1;
        end
    endtask

    task rdc(input string name, input logic [11:0] a, input logic [31:0] exp, input logic eexp);
        apb(0, a, rnd, 4'h0);
        if (!eexp) check(name, rd, exp);
        check("slverr", er, eexp);
    endtask

    task route_chk;
        periph_drv <= rnd[11:0]; pin_a_in <= rnd[17:12]; pin_b_in <= rnd[23:18]; analog_comparator <= rnd[24];
        repeat (5) @(posedge clk);
        sel = {m2[0], m2[1], m2[2], m2[3], m1[2], m1[2]};
        for (int i = 0; i < 6; i++) begin
            ea[2*i+:2] = sel[i] ? 2'b00 : periph_drv[i];
            eb[2*i+:2] = sel[i] ? periph_drv[i] : 2'b00;
        end
        check("pin_a_drv", pin_a_drv, ea);
        check("pin_b_drv", pin_b_drv, eb);
        check("periph_in", periph_in, (sel & pin_b_in) | (~sel & pin_a_in));
        check("link", link, m2[4]);
        check("capture", cap, m2[4] ? analog_comparator : (sel[5] ? pin_b_in[5] : pin_a_in[5]));
    endtask

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        conclude;
    end

    initial begin
        for (int k = 0; k < 4; k++) begin
            rstn <= 0;
            repeat (3) @(posedge clk);
            rstn <= 1;
            m1 = 0; m2 = 0; l1 = 0; l2 = 0;
            rnd = lfsr(rnd);
            v1 = {k[1:0], ~k[0], rnd[4:0]};
            v2 = {k[1:0], rnd[13], ~k[1], rnd[11:8]};
            @(posedge clk);
            rdc("opt1 reset", 12'h000, 0, 0);
            rdc("opt2 reset", 12'h004, 0, 0);
            rdc("status reset", 12'h010, 0, 0);
            wr(12'h000, ~v1, 4'h0);
            wr(12'h000, v1, 4'h1);
            wr(12'h000, ~v1, 4'h1);
            wr(12'h004, v2, 4'h1);
            wr(12'h004, ~v2, 4'h1);
            wr(12'h008, 8'h00, 4'h1);
            wr(12'h00C, ~sor_pkg::SOR_PART_ID[7:0], 4'h1);
            rdc("opt1", 12'h000, m1, 0);
            rdc("opt2", 12'h004, m2, 0);
            rdc("status", 12'h010, {m2[7] & m2[6], 2'b11}, 0);
            rdc("idh", 12'h008, {sor_pkg::SOR_SERIES_BIT, 3'b000, sor_pkg::SOR_PART_ID[11:8]}, 0);
            rdc("idl", 12'h00C, sor_pkg::SOR_PART_ID[7:0], 0);
            rdc("unmapped", 12'h014, 0, 1);
            check("timeout", tmo, m1[7:6]);
            check("permit", permit, m1[5]);
            check("wdog clock", wclk, m2[7]);
            check("window", wwin, m2[7] & m2[6]);
            stop_exec <= 1; rst_wr <= 1; late <= ~k[0];
            @(posedge clk);
            stop_exec <= 0; rst_wr <= 0;
            @(posedge clk);
            check("stop enter", s_enter, m1[5]);
            check("illegal stop", s_ill, !m1[5]);
            check("window reset", wrst, m2[7] & m2[6] & !late);
            rnd = lfsr(rnd);
            route_chk;
            $display("test reset pass %0d done", k);
        end
        conclude;
    end
endmodule // system_option_and_id_regs_test
